// File: design/bss_pkg.sv
// package with boot-source codes, strap layout and timing counts
package bss_pkg;

    // ------------------------------------------------------------
    // strap layout and host configuration
    // ------------------------------------------------------------
    localparam int unsigned MODE_W          = 4;
    localparam logic [1:0]  HOST_CFG_MASTER = 2'h1;

    // ------------------------------------------------------------
    // boot-mode strap codes
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_LP8_SMALL  = 4'h0;
    localparam logic [3:0] CODE_LP8_BIG    = 4'h1;
    localparam logic [3:0] CODE_LP16_SMALL = 4'h2;
    localparam logic [3:0] CODE_LP16_BIG   = 4'h3;
    localparam logic [3:0] CODE_SP8_SMALL  = 4'h4;
    localparam logic [3:0] CODE_SP8_BIG    = 4'h5;
    localparam logic [3:0] CODE_SPI        = 4'h9;
    localparam logic [3:0] CODE_XMODEM     = 4'hb;
    localparam logic [3:0] CODE_DISABLED   = 4'hc;
    localparam logic [3:0] CODE_DDR        = 4'hd;
    localparam logic [3:0] CODE_NOR        = 4'he;

    // ------------------------------------------------------------
    // decoded boot source
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BSS_SRC_NONE,
        BSS_SRC_NAND,
        BSS_SRC_SPI,
        BSS_SRC_UART,
        BSS_SRC_DDR,
        BSS_SRC_NOR
    } bss_src_t;

    // ------------------------------------------------------------
    // nand address cycles and nor window
    // ------------------------------------------------------------
    localparam logic [2:0]  ADDR_CYC_LP_SMALL = 3'h4;
    localparam logic [2:0]  ADDR_CYC_LP_BIG   = 3'h5;
    localparam logic [2:0]  ADDR_CYC_SP_SMALL = 3'h3;
    localparam logic [2:0]  ADDR_CYC_SP_BIG   = 3'h4;
    localparam int unsigned NOR_WINDOW_KB     = 16;
    localparam logic [31:0] NOR_WINDOW_BYTES  = 32'(NOR_WINDOW_KB * 1024);

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 40;
    localparam int unsigned RST_MIN_NS    = 1000;
    localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETTLE_CYC    = 2;

endpackage

// File: design/bss_decode.sv
// strap code decoder: boot source, bus width and nand address cycles
`timescale 1ns/1ps
`default_nettype none

module bss_decode
(
    // strap code
    input  wire logic [3:0]       code_in,
    input  wire logic             master_in,
    // decoded result
    output bss_pkg::bss_src_t     src_out,
    output logic                  byte_wide_out,
    output logic                  large_page_out,
    output logic [2:0]            addr_cyc_out,
    output logic                  reserved_out
);

    // ------------------------------------------------------------
    // decode table
    // ------------------------------------------------------------
    // code table is only honoured in master configuration
    always_comb
    begin
        src_out        = bss_pkg::BSS_SRC_NONE;
        byte_wide_out  = 1'b0;
        large_page_out = 1'b0;
        addr_cyc_out   = 3'h0;
        reserved_out   = 1'b0;
        if (master_in)
        begin
            unique case (code_in)
                bss_pkg::CODE_LP8_SMALL, bss_pkg::CODE_LP8_BIG,
                bss_pkg::CODE_LP16_SMALL, bss_pkg::CODE_LP16_BIG:
                begin
                    src_out        = bss_pkg::BSS_SRC_NAND;
                    large_page_out = 1'b1;
                    byte_wide_out  = ~code_in[1];
                    addr_cyc_out   = code_in[0] ? bss_pkg::ADDR_CYC_LP_BIG
                                                : bss_pkg::ADDR_CYC_LP_SMALL;
                end
                bss_pkg::CODE_SP8_SMALL, bss_pkg::CODE_SP8_BIG:
                begin
                    src_out       = bss_pkg::BSS_SRC_NAND;
                    byte_wide_out = 1'b1;
                    addr_cyc_out  = code_in[0] ? bss_pkg::ADDR_CYC_SP_BIG
                                               : bss_pkg::ADDR_CYC_SP_SMALL;
                end
                bss_pkg::CODE_SPI:      src_out = bss_pkg::BSS_SRC_SPI;
                bss_pkg::CODE_XMODEM:   src_out = bss_pkg::BSS_SRC_UART;
                bss_pkg::CODE_DDR:      src_out = bss_pkg::BSS_SRC_DDR;
                bss_pkg::CODE_NOR:      src_out = bss_pkg::BSS_SRC_NOR;
                bss_pkg::CODE_DISABLED: src_out = bss_pkg::BSS_SRC_NONE;
                default:                reserved_out = 1'b1;
            endcase
        end
    end

endmodule
`default_nettype wire

// File: design/bss_boot_select.sv
// boot-source selector: strap capture after reset and loader dispatch
`timescale 1ns/1ps
`default_nettype none

module bss_boot_select
(
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // board straps and reset pin
    input  wire logic         chip_reset_low_in,
    input  wire logic         clk_sel_in,
    input  wire logic [3:0]   boot_mode_in,
    input  wire logic [1:0]   host_cfg_in,
    // host data bus from boot memory
    input  wire logic [15:0]  host_data_in,
    input  wire logic         host_data_valid_in,
    // loader handshake
    input  wire logic         load_done_in,
    // captured configuration
    output logic              straps_valid_out,
    output logic              clk_sel_out,
    output logic [3:0]        boot_mode_out,
    output logic              master_out,
    output logic              reset_short_out,
    // loader control
    output logic              load_start_out,
    output logic              loading_out,
    output logic              boot_done_out,
    output logic              boot_disabled_out,
    output logic              reserved_code_out,
    output logic              nand_chip_select_out,
    output logic              nor_chip_select_out,
    output logic              spi_select_out,
    output logic              debug_serial_port_out,
    output logic              ddr_select_out,
    output logic              byte_wide_out,
    output logic              large_page_out,
    output logic [2:0]        addr_cyc_out,
    output logic [31:0]       nor_window_out,
    // boot data word
    output logic [15:0]       boot_data_out,
    output logic              boot_data_valid_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BSS_IDLE,
        BSS_SETTLE,
        BSS_LOAD,
        BSS_DONE
    } bss_state_t;

    bss_state_t        state_q;
    logic [5:0]        low_cnt_q;
    logic [1:0]        settle_q;
    logic              pin_prev_q;
    logic [3:0]        mode_q;
    logic [1:0]        host_q;
    logic              clk_sel_q;
    bss_pkg::bss_src_t src_w;
    logic              byte_w;
    logic              large_w;
    logic [2:0]        cyc_w;
    logic              resv_w;
    logic              release_w;

    // refuse a clock rate whose minimum low time overflows the counter
    if (bss_pkg::RST_MIN_CYC > 63)
    begin : g_low_cnt_fit
        $error("reset low count does not fit counter");
    end

    // rising edge of the board reset pin starts the boot sequence
    assign release_w = chip_reset_low_in & ~pin_prev_q;

    // ------------------------------------------------------------
    // reset pin watch
    // ------------------------------------------------------------
    // measure low time of the board reset pin
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pin_prev_q      <= 1'b1;
            low_cnt_q       <= 6'h0;
            reset_short_out <= 1'b0;
        end
        else
        begin
            pin_prev_q <= chip_reset_low_in;
            if (!chip_reset_low_in)
            begin
                if (low_cnt_q != 6'h3f)
                    low_cnt_q <= low_cnt_q + 6'h1;
            end
            else
                low_cnt_q <= 6'h0;
            if (release_w)
                reset_short_out <= (low_cnt_q < 6'(bss_pkg::RST_MIN_CYC));
        end
    end

    // ------------------------------------------------------------
    // strap capture and sequencing
    // ------------------------------------------------------------
    // straps are caught at the pin release, then held
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_q    <= BSS_IDLE;
            settle_q   <= 2'h0;
            mode_q     <= 4'h0;
            host_q     <= 2'h0;
            clk_sel_q  <= 1'b0;
        end
        else if (!chip_reset_low_in)
        begin
            state_q  <= BSS_IDLE;
            settle_q <= 2'h0;
        end
        else
        begin
            unique case (state_q)
                BSS_IDLE:
                    if (release_w)
                    begin
                        mode_q    <= boot_mode_in;
                        host_q    <= host_cfg_in;
                        clk_sel_q <= clk_sel_in;
                        state_q   <= BSS_SETTLE;
                    end
                BSS_SETTLE:
                begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == 2'(bss_pkg::SETTLE_CYC - 1))
                        state_q <= BSS_LOAD;
                end
                BSS_LOAD:
                    if (load_done_in || src_w == bss_pkg::BSS_SRC_NONE)
                        state_q <= BSS_DONE;
                BSS_DONE:
                    state_q <= BSS_DONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    bss_decode u_decode
    (
        .code_in        (mode_q),
        .master_in      (host_q == bss_pkg::HOST_CFG_MASTER),
        .src_out        (src_w),
        .byte_wide_out  (byte_w),
        .large_page_out (large_w),
        .addr_cyc_out   (cyc_w),
        .reserved_out   (resv_w)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // loader selects stand while loading
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            straps_valid_out      <= 1'b0;
            clk_sel_out           <= 1'b0;
            boot_mode_out         <= 4'h0;
            master_out            <= 1'b0;
            load_start_out        <= 1'b0;
            loading_out           <= 1'b0;
            boot_done_out         <= 1'b0;
            boot_disabled_out     <= 1'b0;
            reserved_code_out     <= 1'b0;
            nand_chip_select_out  <= 1'b0;
            nor_chip_select_out   <= 1'b0;
            spi_select_out        <= 1'b0;
            debug_serial_port_out <= 1'b0;
            ddr_select_out        <= 1'b0;
            byte_wide_out         <= 1'b0;
            large_page_out        <= 1'b0;
            addr_cyc_out          <= 3'h0;
            nor_window_out        <= 32'h0;
        end
        else
        begin
            straps_valid_out  <= (state_q != BSS_IDLE);
            clk_sel_out       <= clk_sel_q;
            boot_mode_out     <= mode_q;
            master_out        <= (host_q == bss_pkg::HOST_CFG_MASTER);
            load_start_out    <= (state_q == BSS_SETTLE)
                                 && (settle_q == 2'(bss_pkg::SETTLE_CYC - 1))
                                 && (src_w != bss_pkg::BSS_SRC_NONE);
            loading_out       <= (state_q == BSS_LOAD) && (src_w != bss_pkg::BSS_SRC_NONE);
            boot_done_out     <= (state_q == BSS_DONE);
            boot_disabled_out <= (state_q != BSS_IDLE) && (src_w == bss_pkg::BSS_SRC_NONE);
            reserved_code_out <= (state_q != BSS_IDLE) && resv_w;
            nand_chip_select_out  <= (state_q == BSS_LOAD) && (src_w == bss_pkg::BSS_SRC_NAND);
            nor_chip_select_out   <= (state_q == BSS_LOAD) && (src_w == bss_pkg::BSS_SRC_NOR);
            spi_select_out        <= (state_q == BSS_LOAD) && (src_w == bss_pkg::BSS_SRC_SPI);
            debug_serial_port_out <= (state_q == BSS_LOAD) && (src_w == bss_pkg::BSS_SRC_UART);
            ddr_select_out        <= (state_q == BSS_LOAD) && (src_w == bss_pkg::BSS_SRC_DDR);
            byte_wide_out     <= byte_w;
            large_page_out    <= large_w;
            addr_cyc_out      <= cyc_w;
            nor_window_out    <= (src_w == bss_pkg::BSS_SRC_NOR)
                                 ? bss_pkg::NOR_WINDOW_BYTES : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // boot data lanes
    // ------------------------------------------------------------
    // byte-wide memories deliver on lanes 15:8
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            boot_data_out       <= 16'h0;
            boot_data_valid_out <= 1'b0;
        end
        else
        begin
            boot_data_valid_out <= host_data_valid_in && (state_q == BSS_LOAD);
            if (host_data_valid_in)
                boot_data_out <= byte_w ? {8'h0, host_data_in[15:8]}
                                        : host_data_in;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_strap_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == BSS_IDLE && chip_reset_low_in && release_w)
        |=> (mode_q == $past(boot_mode_in)))
        else $error("boot straps not captured at release");

    a_nand_cycles: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (src_w == bss_pkg::BSS_SRC_NAND && mode_q == bss_pkg::CODE_LP8_BIG)
        |=> (addr_cyc_out == bss_pkg::ADDR_CYC_LP_BIG))
        else $error("wrong nand address cycle count");

    a_lp16_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (master_out && state_q == BSS_LOAD && mode_q == bss_pkg::CODE_LP16_SMALL && $stable(mode_q))
        |=> (!byte_wide_out && large_page_out && nand_chip_select_out))
        else $error("large page 16-bit nand misdecoded");

    a_sp_small: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (master_out && state_q == BSS_LOAD && mode_q == bss_pkg::CODE_SP8_SMALL && $stable(mode_q))
        |-> (byte_wide_out && !large_page_out && addr_cyc_out == bss_pkg::ADDR_CYC_SP_SMALL))
        else $error("small page nand misdecoded");

    a_spi_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == BSS_LOAD && src_w == bss_pkg::BSS_SRC_SPI && chip_reset_low_in)
        |=> spi_select_out || !chip_reset_low_in)
        else $error("spi eeprom not selected");

    a_uart_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        debug_serial_port_out |-> $past(src_w) == bss_pkg::BSS_SRC_UART)
        else $error("debug serial load without its code");

    a_nor_window: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        nor_chip_select_out |-> nor_window_out == bss_pkg::NOR_WINDOW_BYTES)
        else $error("nor window not 16 kbytes");

    a_byte_lanes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (host_data_valid_in && byte_w) |=> boot_data_out == {8'h0, $past(host_data_in[15:8])})
        else $error("byte data not from upper lanes");

    a_slave_none: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!master_out && straps_valid_out) |-> !loading_out && !load_start_out)
        else $error("boot attempted outside master mode");

    a_reserved_off: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        reserved_code_out |-> !loading_out)
        else $error("reserved code started a load");

endmodule
`default_nettype wire

// File: bench/bss_board.sv
// board model: strap pins, reset pin and a four-word boot memory image
`timescale 1ns/1ps
`default_nettype none

module bss_board
(
    // clock, reset and bench commands
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        go_in,
    input  wire logic [3:0]  mode_in,
    input  wire logic [1:0]  cfg_in,
    input  wire logic [7:0]  low_in,
    input  wire logic [15:0] base_in,
    input  wire logic        loading_in,
    // pins toward the device
    output logic             pin_out,
    output logic             sel_out,
    output logic [3:0]       mode_out,
    output logic [1:0]       cfg_out,
    output logic [15:0]      data_out,
    output logic             valid_out,
    output logic             done_out
);
    logic [7:0]  low_q;
    logic [2:0]  word_q;
    logic        narrow_q;
    logic [15:0] w;

    assign w = base_in + {13'h0, word_q};

    // straps follow the bench; the reset pin stays low for the commanded count
    always @(posedge clk_in)
    begin
        sel_out  <= mode_in[0];
        mode_out <= mode_in;
        cfg_out  <= cfg_in;
        if (sys_rst_in)
        begin
            pin_out <= 1'b0;                          // device held in reset at power-up
            low_q   <= 8'h0;
        end
        else if (go_in)
        begin
            pin_out  <= 1'b0;
            low_q    <= low_in;
            narrow_q <= mode_in inside {4'h0, 4'h1, 4'h4, 4'h5};
        end
        else if (low_q != 8'h0)
        begin
            low_q   <= low_q - 8'h1;
            pin_out <= (low_q == 8'h1);
        end
    end

    // one word every other cycle while loading, then a done pulse
    always @(posedge clk_in)
    begin
        valid_out <= 1'b0;
        done_out  <= 1'b0;
        data_out  <= ~data_out;                       // idle lanes invert every cycle, held at 16'h5a5a in reset
        if (sys_rst_in)
        begin
            word_q   <= 3'h0;
            data_out <= 16'h5a5a;
        end
        else if (!pin_out || !loading_in)
            word_q <= 3'h0;
        else if (word_q == 3'h4)
        begin
            done_out <= 1'b1;
            word_q   <= 3'h5;
        end
        else if (word_q < 3'h4 && !valid_out)
        begin
            valid_out <= 1'b1;
            word_q    <= word_q + 3'h1;
            data_out  <= narrow_q ? {w[15:8], ~data_out[7:0]} : w;
        end
    end
endmodule
`default_nettype wire

// File: bench/tb.sv
// testbench: boot-source selection through every strap code and host modes 0, 1 and 3
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk_in, sys_rst_in, go, pin, sel, vld, done;
    logic [3:0]  mode, mode_p, bmode;
    logic [1:0]  cfg, cfg_p;
    logic [7:0]  low;
    logic [15:0] base, data, bdata;
    logic        sv, csel, mst, rshort, lstart, loading, bdone, bdis, rsv;
    logic        nand_cs, nor_cs, spi, uart, ddr, bw, lp, bvld;
    logic [2:0]  acyc;
    logic [31:0] nwin;
    int          n_fail, checked, n_start;

    // ------------------------------------------------------------
    // board model and device
    // ------------------------------------------------------------
    bss_board bss_board_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .go_in(go),
        .mode_in(mode), .cfg_in(cfg), .low_in(low), .base_in(base), .loading_in(loading),
        .pin_out(pin), .sel_out(sel), .mode_out(mode_p), .cfg_out(cfg_p),
        .data_out(data), .valid_out(vld), .done_out(done));

    bss_boot_select bss_boot_select_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .chip_reset_low_in(pin), .clk_sel_in(sel), .boot_mode_in(mode_p),
        .host_cfg_in(cfg_p), .host_data_in(data), .host_data_valid_in(vld),
        .load_done_in(done), .straps_valid_out(sv), .clk_sel_out(csel),
        .boot_mode_out(bmode), .master_out(mst), .reset_short_out(rshort),
        .load_start_out(lstart), .loading_out(loading), .boot_done_out(bdone),
        .boot_disabled_out(bdis), .reserved_code_out(rsv),
        .nand_chip_select_out(nand_cs), .nor_chip_select_out(nor_cs),
        .spi_select_out(spi), .debug_serial_port_out(uart), .ddr_select_out(ddr),
        .byte_wide_out(bw), .large_page_out(lp), .addr_cyc_out(acyc),
        .nor_window_out(nwin), .boot_data_out(bdata), .boot_data_valid_out(bvld));

    // ------------------------------------------------------------
    // clock, start pulse counter, comparison and verdict
    // ------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    always @(negedge clk_in)
        if (lstart === 1'b1)
            n_start++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // one full boot: straps changed after capture, data lanes, completion
    // ------------------------------------------------------------
    task automatic boot(input logic [3:0] c, input logic [1:0] hc, input logic [7:0] lc);
        logic        ld, r, nr;
        logic [2:0]  ac;
        logic [15:0] w;
        int          i;
        r  = c inside {4'h6, 4'h7, 4'h8, 4'ha, 4'hf};
        ld = !r && c != bss_pkg::CODE_DISABLED && hc == bss_pkg::HOST_CFG_MASTER;
        nr = c inside {4'h0, 4'h1, 4'h4, 4'h5};
        ac = c < 4'h4 ? (c[0] ? bss_pkg::ADDR_CYC_LP_BIG : bss_pkg::ADDR_CYC_LP_SMALL)
                      : (c[0] ? bss_pkg::ADDR_CYC_SP_BIG : bss_pkg::ADDR_CYC_SP_SMALL);
        @(posedge clk_in);
        {mode, cfg, low, go} <= {c, hc, lc, 1'b1};
        base <= {c, 12'h3c5};
        @(posedge clk_in);
        go <= 1'b0;
        n_start = 0;
        @(negedge clk_in);
        for (i = 0; i < 300 && pin !== 1'b1; i++)
            @(negedge clk_in);
        repeat (3) @(negedge clk_in);
        check({sv, bmode, csel}, {1'b1, c, c[0]});
        check({mst, rshort}, {hc == 2'h1, lc < 8'd40});
        @(posedge clk_in);
        mode <= ~c;
        for (i = 0; i < 8 && loading !== 1'b1 && bdone !== 1'b1; i++)
            @(negedge clk_in);
        if (ld)
        begin
            check({loading, nand_cs, nor_cs, spi, uart, ddr},
                  {1'b1, c < 4'h6, c == 4'he, c == 4'h9, c == 4'hb, c == 4'hd});
            if (c < 4'h6)
                check({bw, lp, acyc}, {nr, c < 4'h4, ac});
            check(nwin, c == bss_pkg::CODE_NOR ? bss_pkg::NOR_WINDOW_BYTES : 32'h0);
            for (int k = 0; k < 4; k++)
            begin
                w = {c, 12'h3c5} + 16'(k);
                for (i = 0; i < 8 && bvld !== 1'b1; i++)
                    @(negedge clk_in);
                check(bdata, nr ? {8'h0, w[15:8]} : w);
                @(negedge clk_in);
            end
        end
        for (i = 0; i < 12 && bdone !== 1'b1; i++)
            @(negedge clk_in);
        check({bdone, loading, nand_cs, nor_cs, spi, uart, ddr}, 7'h40);
        check({bdis, rsv, n_start[1:0]}, {!ld, r, 1'b0, ld});
        check(bmode, c);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_codes;
        for (int c = 0; c < 16; c++)
            boot(4'(c), 2'h1, 8'd48);
    endtask

    task automatic t_slave;
        boot(4'h0, 2'h0, 8'd48);
        boot(4'h3, 2'h3, 8'd48);
        boot(bss_pkg::CODE_DISABLED, 2'h0, 8'd48);
    endtask

    task automatic t_short;
        boot(4'h9, 2'h1, 8'd20);
    endtask

    // reset pin pulled low in mid-load, then a second boot runs through
    task automatic t_abort;
        int i;
        @(posedge clk_in);
        {mode, cfg, low, go} <= {4'hd, 2'h1, 8'd48, 1'b1};
        @(posedge clk_in);
        go <= 1'b0;
        n_start = 0;
        for (i = 0; i < 300 && loading !== 1'b1; i++)
            @(negedge clk_in);
        @(posedge clk_in);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (4) @(negedge clk_in);
        check({loading, ddr, bdone}, 3'h0);
        for (i = 0; i < 300 && bdone !== 1'b1; i++)
            @(negedge clk_in);
        check({bdone, n_start[1:0]}, {1'b1, 2'h2});
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        {sys_rst_in, go, mode, cfg, low, base} = {1'b1, 1'b0, 4'h0, 2'h1, 8'd48, 16'h0};
        n_fail = 0;
        checked = 0;
        n_start = 0;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        check({sv, lstart, loading, bdone, bdis}, 5'h0);
        t_codes;
        t_slave;
        t_short;
        t_abort;
        give_verdict;
    end

    initial
    begin
        #200us;
        n_fail++;
        give_verdict;
    end
endmodule
`default_nettype wire
